// file: shared/uiebd_defines.vh
`ifndef UIEBD_DEFINES_VH
`define UIEBD_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
`define UIEBD_ADDR_W          12
`define UIEBD_OFF_IRQ_STATUS  12'h000
`define UIEBD_OFF_IRQ_MASK    12'h004
`define UIEBD_EP_SEL_MSB      6
`define UIEBD_EP_SEL_LSB      4
`define UIEBD_REG_SEL_MSB     3
`define UIEBD_REG_SEL_LSB     2
`define UIEBD_HIGH_MSB        11
`define UIEBD_HIGH_LSB        7
`define UIEBD_REG_X_COUNT     2'h0
`define UIEBD_REG_Y_COUNT     2'h1
`define UIEBD_REG_Y_BASE      2'h2
`define UIEBD_REG_CONFIG      2'h3
`define UIEBD_EP_GLOBAL       3'h0
`define UIEBD_ALIGN_MSB       1

// ****************************************************************
// Field layouts
// ****************************************************************
`define UIEBD_CNT_EMPTY_BIT   7
`define UIEBD_CNT_MSB         6
`define UIEBD_BASE_MSB        7
`define UIEBD_CFG_ISO_BIT     0
`define UIEBD_CFG_DUAL_BIT    1
`define UIEBD_CFG_TOGGLE_BIT  2
`define UIEBD_CFG_NEXT_Y_BIT  3
`define UIEBD_CFG_SIZE_MSB    12
`define UIEBD_CFG_SIZE_LSB    8
`define UIEBD_BASE_LOW_ZERO   3'h0

// ****************************************************************
// Reset values
// ****************************************************************
`define UIEBD_RST_COUNT       7'h00
`define UIEBD_RST_BASE        8'h00
`define UIEBD_RST_SIZE        5'h00
`define UIEBD_RST_EPS         7'h00

`endif

// file: design/uiebd_len_calc.v
`timescale 1ns/10ps
`default_nettype none
`include "uiebd_defines.vh"

module uiebd_len_calc
(
	// Descriptor fields of the selected endpoint
	input  wire [6:0]  count_in,
	input  wire        iso_in,
	input  wire [4:0]  sample_size_in,
	input  wire [7:0]  y_base_addr_in,
	// Derived values
	output wire [11:0] byte_len_out,
	output wire [10:0] y_start_addr_out
);
	wire [5:0]  bytes_per_sample;
	wire [12:0] product;

	assign bytes_per_sample = {1'b0, sample_size_in} + 6'h01;
	assign product          = {6'h00, count_in} * {7'h00, bytes_per_sample};

	assign byte_len_out = iso_in ? product[11:0] : {5'h00, count_in};

	assign y_start_addr_out = {y_base_addr_in, `UIEBD_BASE_LOW_ZERO};
endmodule // uiebd_len_calc

`default_nettype wire

// file: design/uiebd_ep_desc.v
`timescale 1ns/10ps
`default_nettype none
`include "uiebd_defines.vh"

module uiebd_ep_desc
(
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        rst_in,
	// Register writes
	input  wire [3:0]  wr_sel_in,
	input  wire [15:0] wdata_in,
	// Successful IN transaction on this endpoint
	input  wire        served_in,
	// Descriptor state
	output wire [6:0]  x_packet_count_out,
	output wire        x_empty_out,
	output wire [6:0]  y_packet_count_out,
	output wire        y_empty_out,
	output wire [7:0]  y_base_addr_out,
	output wire        iso_out,
	output wire        dual_buffer_out,
	output wire        toggle_out,
	output wire        next_y_out,
	output wire [4:0]  sample_size_out
);
	reg  [6:0]  x_packet_count_r;
	reg         x_empty_r;
	reg  [6:0]  y_packet_count_r;
	reg         y_empty_r;
	reg  [7:0]  y_base_addr_r;
	reg         iso_r;
	reg         dual_buffer_r;
	reg         toggle_r;
	reg         next_y_r;
	reg  [4:0]  sample_size_r;

	assign x_packet_count_out = x_packet_count_r;
	assign x_empty_out        = x_empty_r;
	assign y_packet_count_out = y_packet_count_r;
	assign y_empty_out        = y_empty_r;
	assign y_base_addr_out    = y_base_addr_r;
	assign iso_out            = iso_r;
	assign dual_buffer_out    = dual_buffer_r;
	assign toggle_out         = toggle_r;
	assign next_y_out         = next_y_r;
	assign sample_size_out    = sample_size_r;

	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			x_packet_count_r <= `UIEBD_RST_COUNT;
			x_empty_r        <= 1'b0;
			y_packet_count_r <= `UIEBD_RST_COUNT;
			y_empty_r        <= 1'b0;
			y_base_addr_r    <= `UIEBD_RST_BASE;
			iso_r            <= 1'b0;
			dual_buffer_r    <= 1'b0;
			toggle_r         <= 1'b0;
			next_y_r         <= 1'b0;
			sample_size_r    <= `UIEBD_RST_SIZE;
		end
		else
		begin
			if (wr_sel_in[`UIEBD_REG_X_COUNT])
			begin
				x_packet_count_r <= wdata_in[`UIEBD_CNT_MSB:0];
				x_empty_r        <= wdata_in[`UIEBD_CNT_EMPTY_BIT];
			end
			if (wr_sel_in[`UIEBD_REG_Y_COUNT])
			begin
				y_packet_count_r <= wdata_in[`UIEBD_CNT_MSB:0];
				y_empty_r        <= wdata_in[`UIEBD_CNT_EMPTY_BIT];
			end
			if (wr_sel_in[`UIEBD_REG_Y_BASE])
				y_base_addr_r <= wdata_in[`UIEBD_BASE_MSB:0];
			if (wr_sel_in[`UIEBD_REG_CONFIG])
			begin
				iso_r         <= wdata_in[`UIEBD_CFG_ISO_BIT];
				dual_buffer_r <= wdata_in[`UIEBD_CFG_DUAL_BIT];
				toggle_r      <= wdata_in[`UIEBD_CFG_TOGGLE_BIT];
				next_y_r      <= wdata_in[`UIEBD_CFG_NEXT_Y_BIT];
				sample_size_r <= wdata_in[`UIEBD_CFG_SIZE_MSB:`UIEBD_CFG_SIZE_LSB];
			end
			// A completion wins over a software write in the same cycle.
			if (served_in)
			begin
				if (next_y_r)
					y_empty_r <= 1'b1;
				else
					x_empty_r <= 1'b1;
				toggle_r <= ~toggle_r;
				next_y_r <= dual_buffer_r & ~iso_r & ~next_y_r;
			end
			else if (~dual_buffer_r | iso_r)
				next_y_r <= 1'b0;
		end
	end
endmodule // uiebd_ep_desc

`default_nettype wire

// file: design/uiebd_top.v
`timescale 1ns/10ps
`default_nettype none
`include "uiebd_defines.vh"

module uiebd_top #
(
	parameter NUM_EPS = 7
)
(
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        rst_in,
	// APB slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// IN token from the USB engine
	input  wire        in_token_in,
	input  wire [2:0]  in_ep_in,
	// Outcome of the data stage
	input  wire        in_ack_in,
	input  wire        in_abort_in,
	// Answer to the USB engine
	output reg         resp_valid_out,
	output reg         resp_nak_out,
	output reg         resp_data_out,
	output reg         resp_pid_data1_out,
	output reg         resp_use_y_out,
	output reg  [10:0] resp_y_addr_out,
	output reg  [11:0] resp_byte_len_out,
	// Interrupt
	output reg         irq_out
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam [2:0] ST_IDLE   = 3'b001;
	localparam [2:0] ST_ANSWER = 3'b010;
	localparam [2:0] ST_WAIT   = 3'b100;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [2:0]  cur_ep_r;
	reg  [6:0]  irq_status_r;
	reg  [6:0]  irq_mask_r;
	reg  [6:0]  irq_status_nxt;
	reg  [6:0]  irq_mask_nxt;

	wire        apb_write;
	wire        apb_setup;
	wire [2:0]  sel_ep;
	wire [1:0]  sel_reg;
	wire        addr_ok;
	wire [6:0]  served;
	wire [6:0]  ep_events;
	wire        tok_take;
	wire        irq_nxt;

	// Per endpoint descriptor buses.
	wire [6:0]  x_cnt    [0:6];
	wire [6:0]  y_cnt    [0:6];
	wire [7:0]  y_base   [0:6];
	wire [4:0]  smp_size [0:6];
	wire [6:0]  x_empty;
	wire [6:0]  y_empty;
	wire [6:0]  iso;
	wire [6:0]  dual;
	wire [6:0]  toggle;
	wire [6:0]  next_y;

	// ****************************************************************
	// Decoding
	// ****************************************************************
	function [6:0] ep_onehot;
		input [2:0] ep;
		begin
			case (ep)
				3'h1:    ep_onehot = 7'h01;
				3'h2:    ep_onehot = 7'h02;
				3'h3:    ep_onehot = 7'h04;
				3'h4:    ep_onehot = 7'h08;
				3'h5:    ep_onehot = 7'h10;
				3'h6:    ep_onehot = 7'h20;
				3'h7:    ep_onehot = 7'h40;
				default: ep_onehot = 7'h00;
			endcase
		end
	endfunction

	function [3:0] reg_onehot;
		input [1:0] r;
		begin
			reg_onehot = 4'h0;
			reg_onehot[r] = 1'b1;
		end
	endfunction

	function [2:0] ep_to_idx;
		input [2:0] ep;
		begin
			ep_to_idx = ep - 3'h1;
		end
	endfunction

	function is_global;
		input [2:0] ep;
		begin
			is_global = (ep == `UIEBD_EP_GLOBAL);
		end
	endfunction

	assign sel_ep    = paddr_in[`UIEBD_EP_SEL_MSB:`UIEBD_EP_SEL_LSB];
	assign sel_reg   = paddr_in[`UIEBD_REG_SEL_MSB:`UIEBD_REG_SEL_LSB];
	assign addr_ok   = (paddr_in[`UIEBD_HIGH_MSB:`UIEBD_HIGH_LSB] == 5'h00) &&
	                   (paddr_in[`UIEBD_ALIGN_MSB:0] == 2'h0) &&
	                   (!is_global(sel_ep) || (sel_reg == `UIEBD_REG_X_COUNT) ||
	                    (sel_reg == `UIEBD_REG_Y_COUNT));
	assign apb_setup = psel_in & ~penable_in;
	assign apb_write = psel_in & penable_in & pready_out & pwrite_in & addr_ok;

	// ****************************************************************
	// Endpoint descriptors
	// ****************************************************************
	// Only a completed data stage counts as an event; a NAK or an abort does not.
	assign served    = (state_r == ST_WAIT && in_ack_in) ? ep_onehot(cur_ep_r) : 7'h00;
	assign ep_events = served;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EPS; gi = gi + 1)
		begin : g_ep
			wire [3:0] wsel;
			assign wsel = (apb_write && sel_ep == gi + 1) ? reg_onehot(sel_reg) : 4'h0;
			uiebd_ep_desc u_desc
			(
				.clk_sys_in         (clk_sys_in),
				.rst_in             (rst_in),
				.wr_sel_in          (wsel),
				.wdata_in           (pwdata_in[15:0]),
				.served_in          (served[gi]),
				.x_packet_count_out (x_cnt[gi]),
				.x_empty_out        (x_empty[gi]),
				.y_packet_count_out (y_cnt[gi]),
				.y_empty_out        (y_empty[gi]),
				.y_base_addr_out    (y_base[gi]),
				.iso_out            (iso[gi]),
				.dual_buffer_out    (dual[gi]),
				.toggle_out         (toggle[gi]),
				.next_y_out         (next_y[gi]),
				.sample_size_out    (smp_size[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Response of the addressed endpoint
	// ****************************************************************
	wire [2:0]  tok_idx;
	wire [6:0]  tok_count;
	wire        tok_empty;
	wire        tok_nak;
	wire [11:0] tok_len;
	wire [10:0] tok_addr;

	assign tok_take  = (state_r == ST_IDLE) && in_token_in && !is_global(in_ep_in);
	assign tok_idx   = ep_to_idx(in_ep_in);
	assign tok_count = next_y[tok_idx] ? y_cnt[tok_idx] : x_cnt[tok_idx];
	assign tok_empty = next_y[tok_idx] ? y_empty[tok_idx] : x_empty[tok_idx];
	assign tok_nak   = tok_empty & ~iso[tok_idx];

	uiebd_len_calc u_len
	(
		.count_in         (tok_count),
		.iso_in           (iso[tok_idx]),
		.sample_size_in   (smp_size[tok_idx]),
		.y_base_addr_in   (y_base[tok_idx]),
		.byte_len_out     (tok_len),
		.y_start_addr_out (tok_addr)
	);

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (tok_take)
					state_nxt = ST_ANSWER;
			ST_ANSWER:
				state_nxt = resp_nak_out ? ST_IDLE : ST_WAIT;
			ST_WAIT:
				if (in_ack_in || in_abort_in)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_r            <= ST_IDLE;
			cur_ep_r           <= 3'h0;
			resp_valid_out     <= 1'b0;
			resp_nak_out       <= 1'b0;
			resp_data_out      <= 1'b0;
			resp_pid_data1_out <= 1'b0;
			resp_use_y_out     <= 1'b0;
			resp_y_addr_out    <= 11'h000;
			resp_byte_len_out  <= 12'h000;
		end
		else
		begin
			state_r        <= state_nxt;
			resp_valid_out <= 1'b0;
			// Tokens met while an answer or a data stage is pending are dropped.
			// The answer fields stand until the next accepted token.
			if (tok_take)
			begin
				cur_ep_r           <= in_ep_in;
				resp_valid_out     <= 1'b1;
				resp_nak_out       <= tok_nak;
				resp_data_out      <= ~tok_nak;
				resp_pid_data1_out <= toggle[tok_idx];
				resp_use_y_out     <= next_y[tok_idx];
				resp_y_addr_out    <= tok_addr;
				resp_byte_len_out  <= tok_len;
			end
		end
	end

	// ****************************************************************
	// Interrupt status and mask
	// ****************************************************************
	// A new event wins over a write-one-to-clear in the same cycle.
	always @*
	begin
		irq_status_nxt = irq_status_r | ep_events;
		irq_mask_nxt   = irq_mask_r;
		if (apb_write && paddr_in == `UIEBD_OFF_IRQ_STATUS)
			irq_status_nxt = (irq_status_r & ~pwdata_in[6:0]) | ep_events;
		if (apb_write && paddr_in == `UIEBD_OFF_IRQ_MASK)
			irq_mask_nxt = pwdata_in[6:0];
	end

	assign irq_nxt = |(irq_status_r & irq_mask_r);

	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			irq_status_r <= `UIEBD_RST_EPS;
			irq_mask_r   <= `UIEBD_RST_EPS;
			irq_out      <= 1'b0;
		end
		else
		begin
			irq_status_r <= irq_status_nxt;
			irq_mask_r   <= irq_mask_nxt;
			irq_out      <= irq_nxt;
		end
	end

	// ****************************************************************
	// APB read data and ready
	// ****************************************************************
	reg [31:0] rd_mux;
	reg [2:0]  rd_idx;

	always @*
	begin
		rd_idx = ep_to_idx(sel_ep);
		rd_mux = 32'h0000_0000;
		if (is_global(sel_ep))
		begin
			if (sel_reg == `UIEBD_REG_X_COUNT)
				rd_mux = {25'h0000000, irq_status_r};
			else
				rd_mux = {25'h0000000, irq_mask_r};
		end
		else
		begin
			case (sel_reg)
				`UIEBD_REG_X_COUNT: rd_mux = {24'h000000, x_empty[rd_idx], x_cnt[rd_idx]};
				`UIEBD_REG_Y_COUNT: rd_mux = {24'h000000, y_empty[rd_idx], y_cnt[rd_idx]};
				`UIEBD_REG_Y_BASE:  rd_mux = {24'h000000, y_base[rd_idx]};
				default:            rd_mux = {19'h00000, smp_size[rd_idx], 4'h0,
				                              next_y[rd_idx], toggle[rd_idx],
				                              dual[rd_idx], iso[rd_idx]};
			endcase
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end
		else
		begin
			// Zero wait states: ready follows each setup cycle by one clock.
			pready_out  <= apb_setup;
			pslverr_out <= apb_setup & ~addr_ok;
			if (apb_setup && !pwrite_in && addr_ok)
				prdata_out <= rd_mux;
			else if (apb_setup)
				prdata_out <= 32'h0000_0000;
		end
	end
endmodule // uiebd_top

`default_nettype wire

// file: sim/uiebd_monitor.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module uiebd_monitor #
(
	parameter NUM_EPS = 7
)
(
	// Clock and reset
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	// Register bus
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	// Token side
	input wire logic        in_token_in,
	input wire logic [2:0]  in_ep_in,
	input wire logic        in_ack_in,
	input wire logic        resp_valid_out,
	input wire logic        resp_nak_out,
	input wire logic        resp_data_out,
	input wire logic        resp_use_y_out,
	input wire logic [10:0] resp_y_addr_out,
	input wire logic        irq_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in && pready_out;
	endsequence

	a_access_at_once: assert property (s_setup |=> s_access)
		else $error("access phase not answered in the next cycle");
	a_error_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("error flag without ready");
	a_answer_has_token: assert property (resp_valid_out |-> $past(in_token_in) && $past(in_ep_in) != 3'h0)
		else $error("answer without a token one cycle earlier");
	a_answer_pulse: assert property (resp_valid_out |=> !resp_valid_out)
		else $error("answer valid longer than one cycle");
	a_nak_or_data: assert property (resp_valid_out |-> resp_nak_out ^ resp_data_out)
		else $error("answer is not exactly one of nak or data");
	a_y_addr_aligned: assert property (resp_valid_out && resp_use_y_out |-> resp_y_addr_out[2:0] == 3'h0)
		else $error("Y start address low bits not zero");
	a_answer_held: assert property (!resp_valid_out && !$past(rst_in) |-> $stable(resp_nak_out) && $stable(resp_use_y_out) && $stable(resp_y_addr_out))
		else $error("answer fields changed between answers");
	a_irq_has_cause: assert property ($rose(irq_out) |-> $past(in_ack_in, 2) || $past(psel_in && penable_in && pwrite_in, 2))
		else $error("interrupt rose without a served transfer or a write");
endmodule // uiebd_monitor

bind uiebd_top uiebd_monitor #(.NUM_EPS(NUM_EPS)) u_uiebd_monitor
(
	.clk_sys_in,
	.rst_in,
	.psel_in,
	.penable_in,
	.pwrite_in,
	.pready_out,
	.pslverr_out,
	.in_token_in,
	.in_ep_in,
	.in_ack_in,
	.resp_valid_out,
	.resp_nak_out,
	.resp_data_out,
	.resp_use_y_out,
	.resp_y_addr_out,
	.irq_out
);

`default_nettype wire

// file: sim/uiebd_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host controller polling IN endpoints
// ****************************************************************
module uiebd_host_model
(
	// Clock
	input wire logic        clk_sys_in,
	// Token and outcome
	output var logic        tok_out,
	output var logic [2:0]  ep_out,
	output var logic        ack_out,
	output var logic        abort_out,
	// Answer
	input wire logic        resp_valid_in,
	input wire logic        resp_data_in,
	input wire logic [26:0] answer_in
);
	initial
	begin
		tok_out = 1'b0;
		ep_out = 3'h0;
		ack_out = 1'b0;
		abort_out = 1'b0;
	end

	task automatic poll(input logic [2:0] ep, input logic ab, input int dly,
		output logic [26:0] got);
		@(posedge clk_sys_in);
		tok_out <= 1'b1;
		ep_out <= ep;
		// The token stands until its answer is seen.
		do
			@(posedge clk_sys_in);
		while (resp_valid_in !== 1'b1);
		got = answer_in;
		tok_out <= 1'b0;
		// Endpoint lines are scrambled once the answer is taken.
		ep_out <= ~ep;
		if (resp_data_in === 1'b1)
		begin
			repeat (dly) @(posedge clk_sys_in);
			ack_out <= !ab;
			abort_out <= ab;
			@(posedge clk_sys_in);
			ack_out <= 1'b0;
			abort_out <= 1'b0;
		end
		@(posedge clk_sys_in);
	endtask
endmodule // uiebd_host_model

`default_nettype wire

// file: sim/tb_usb_in_endpoint_buffer_descriptors.sv
`timescale 1ns/10ps
`default_nettype none
`include "uiebd_defines.vh"
`define CHK(what, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			$display("wrong value %s expected %h seen %h", what, exp, got); \
			err_count++; \
		end \
	end

module tb_usb_in_endpoint_buffer_descriptors;
	logic        clk_sys_in;
	logic        rst_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in;
	wire  [31:0] prdata_out;
	wire         pready_out;
	wire         pslverr_out;
	wire         tok;
	wire  [2:0]  ep;
	wire         ack;
	wire         abort;
	wire         resp_valid_out;
	wire         resp_nak_out;
	wire         resp_data_out;
	wire         resp_pid_data1_out;
	wire         resp_use_y_out;
	wire  [10:0] resp_y_addr_out;
	wire  [11:0] resp_byte_len_out;
	wire         irq_out;
	wire  [26:0] answer;
	int          err_count;
	int          n_compared;
	int          cycles;
	logic [31:0] rd;
	logic        err;

	assign answer = {resp_nak_out, resp_data_out, resp_pid_data1_out, resp_use_y_out,
		resp_y_addr_out, resp_byte_len_out};

	uiebd_top #(.NUM_EPS(7)) u_uiebd_top
	(
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .in_token_in(tok), .in_ep_in(ep), .in_ack_in(ack),
		.in_abort_in(abort), .resp_valid_out(resp_valid_out), .resp_nak_out(resp_nak_out),
		.resp_data_out(resp_data_out), .resp_pid_data1_out(resp_pid_data1_out),
		.resp_use_y_out(resp_use_y_out), .resp_y_addr_out(resp_y_addr_out),
		.resp_byte_len_out(resp_byte_len_out), .irq_out(irq_out)
	);

	uiebd_host_model u_uiebd_host_model
	(
		.clk_sys_in(clk_sys_in), .tok_out(tok), .ep_out(ep), .ack_out(ack),
		.abort_out(abort), .resp_valid_in(resp_valid_out), .resp_data_in(resp_data_out),
		.answer_in(answer)
	);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_count++;
			test_done();
		end
	end

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [11:0] ra(input logic [2:0] e, input logic [1:0] r);
		return {5'h00, e, r, 2'h0};
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do
			@(posedge clk_sys_in);
		while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		`CHK("register", exp, rd)
	endtask

	task automatic expect_data(input logic [2:0] e, input logic ab, input int dly,
		input logic pid, input logic y, input logic [10:0] a, input logic [11:0] len);
		logic [26:0] got;
		u_uiebd_host_model.poll(e, ab, dly, got);
		if (!y)
			got[22:12] = a;
		`CHK("answer", {2'b01, pid, y, a, len}, got)
	endtask

	task automatic expect_nak(input logic [2:0] e);
		logic [26:0] got;
		u_uiebd_host_model.poll(e, 1'b0, 0, got);
		`CHK("nak answer", 2'b10, got[26:25])
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		rst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd_chk(ra(3'h1, `UIEBD_REG_X_COUNT), 32'h0);
		rd_chk(ra(3'h7, `UIEBD_REG_CONFIG), 32'h0);
		apb(1'b0, 12'h080, 32'h0);
		`CHK("unmapped error", 1'b1, err)
		apb(1'b1, 12'h011, 32'h7f);
		`CHK("unaligned error", 1'b1, err)
		rd_chk(ra(3'h1, `UIEBD_REG_X_COUNT), 32'h0);
		for (int i = 1; i < 8; i++)
		begin
			apb(1'b1, ra(i[2:0], `UIEBD_REG_Y_BASE), 32'h11 * i);
			rd_chk(ra(i[2:0], `UIEBD_REG_Y_BASE), 32'h11 * i);
		end
		$display("test registers done");
		apb(1'b1, ra(3'h2, `UIEBD_REG_X_COUNT), 32'h05);
		expect_data(3'h2, 1'b0, 0, 1'b0, 1'b0, 11'h0, 12'h005);
		rd_chk(ra(3'h2, `UIEBD_REG_X_COUNT), 32'h85);
		rd_chk(ra(3'h2, `UIEBD_REG_CONFIG), 32'h04);
		expect_nak(3'h2);
		rd_chk(12'h000, 32'h02);
		apb(1'b1, 12'h004, 32'h02);
		repeat (2) @(posedge clk_sys_in);
		`CHK("irq set", 1'b1, irq_out)
		apb(1'b1, 12'h000, 32'h02);
		repeat (2) @(posedge clk_sys_in);
		`CHK("irq clear", 1'b0, irq_out)
		apb(1'b1, ra(3'h2, `UIEBD_REG_X_COUNT), 32'h06);
		expect_data(3'h2, 1'b0, 5, 1'b1, 1'b0, 11'h0, 12'h006);
		$display("test single buffer done");
		apb(1'b1, ra(3'h3, `UIEBD_REG_CONFIG), 32'h02);
		apb(1'b1, ra(3'h3, `UIEBD_REG_Y_BASE), 32'h12);
		apb(1'b1, ra(3'h3, `UIEBD_REG_X_COUNT), 32'h03);
		apb(1'b1, ra(3'h3, `UIEBD_REG_Y_COUNT), 32'h04);
		expect_data(3'h3, 1'b0, 0, 1'b0, 1'b0, 11'h0, 12'h003);
		expect_data(3'h3, 1'b1, 2, 1'b1, 1'b1, 11'h090, 12'h004);
		expect_data(3'h3, 1'b0, 0, 1'b1, 1'b1, 11'h090, 12'h004);
		rd_chk(ra(3'h3, `UIEBD_REG_Y_COUNT), 32'h84);
		expect_nak(3'h3);
		$display("test dual buffer done");
		for (int s = 0; s < 32; s++)
		begin
			apb(1'b1, ra(3'h4, `UIEBD_REG_CONFIG), 32'h01 | (s << 8));
			apb(1'b1, ra(3'h4, `UIEBD_REG_X_COUNT), 32'h7f);
			expect_data(3'h4, 1'b0, 0, 1'b0, 1'b0, 11'h0, 12'(127 * (s + 1)));
			expect_data(3'h4, 1'b0, 1, 1'b1, 1'b0, 11'h0, 12'(127 * (s + 1)));
			apb(1'b1, ra(3'h4, `UIEBD_REG_X_COUNT), 32'h7f);
		end
		$display("test isochronous done");
		test_done();
	end
endmodule // tb_usb_in_endpoint_buffer_descriptors

`default_nettype wire
